// ==== src/kls_supervisor.v ====
// knock level supervisor: gated band energy, limits, retard ramp, flags,
// and the host side of the parameter store.
// assumes band_sample is the band-pass output on mclk; cycle_gate is a pin.
`timescale 1ns/1ns
`include "kls_regs.vh"

module kls_supervisor
(
    mclk,
    rst_n,
    cycle_gate,
    band_sample,
    sample_valid,
    par_wr,
    par_addr,
    par_wdata,
    connect_req,
    compare_settings_cmd,
    cmp_addr,
    cmp_data,
    host_busy_ff,
    rep_valid_ff,
    rep_addr_ff,
    rep_data_ff,
    cmp_done_ff,
    cmp_match_ff,
    knocking_ff,
    power_cut_request_ff,
    trip_ff,
    volt_code_ff,
    cur_code_ff
);
    parameter TICK_CYCLES = `KLS_TICK_CYCLES;
    parameter FW_VERSION = 16'h0102; // arbitrary value
    input wire mclk;
    input wire rst_n;
    input wire cycle_gate;
    input wire signed [11:0] band_sample;
    input wire sample_valid;
    input wire par_wr;
    input wire [2:0] par_addr;
    input wire [15:0] par_wdata;
    input wire connect_req;
    input wire compare_settings_cmd;
    input wire [2:0] cmp_addr;
    input wire [15:0] cmp_data;
    output reg host_busy_ff;
    output reg rep_valid_ff;
    output reg [2:0] rep_addr_ff;
    output reg [15:0] rep_data_ff;
    output reg cmp_done_ff;
    output reg cmp_match_ff;
    output reg knocking_ff;
    output reg power_cut_request_ff;
    output reg trip_ff;
    output reg [11:0] volt_code_ff;
    output reg [11:0] cur_code_ff;

    localparam ST_IDLE = 2'b00;
    localparam ST_VERSION = 2'b01;
    localparam ST_REPORT = 2'b10;
    localparam ST_VERIFY = 2'b11;

    reg gate_s1_ff, gate_s2_ff, gate_d_ff;
    reg [31:0] energy_ff;
    reg [15:0] lim_ff, shut_ff, decay_ff, hold_ms_ff, rise_ff;
    reg [11:0] level_ff;
    reg [15:0] hold_ff;
    reg [16:0] tick_cnt_ff;
    reg tick_ff;
    reg [1:0] state_ff;
    reg [2:0] seq_addr_ff;
    reg rd_pend_ff;
    reg [15:0] cmp_data_ff;
    wire [15:0] rd_data;
    wire [23:0] sq;
    wire [31:0] sq_ext;
    wire [32:0] sum;
    wire cycle_end;
    wire knock_now;
    wire [12:0] level_up;
    wire [25:0] cur_prod;
    wire rd_en;
    wire [2:0] rd_addr;

    assign sq = {{12{band_sample[11]}}, band_sample}
        * {{12{band_sample[11]}}, band_sample};
    assign sq_ext = {16'h0000, sq[23:`KLS_ENERGY_SHIFT]};
    assign sum = {1'b0, energy_ff} + {1'b0, sq_ext};
    assign cycle_end = gate_d_ff && !gate_s2_ff;
    assign knock_now = energy_ff >= {16'h0000, lim_ff};
    assign level_up = {1'b0, level_ff} + {1'b0, rise_ff[11:0]};
    assign cur_prod = {14'h0000, level_ff} * {12'h000, `KLS_CUR_MULT};
    assign rd_en = (state_ff == ST_REPORT && !rd_pend_ff)
        || (state_ff == ST_IDLE && compare_settings_cmd);
    assign rd_addr = (state_ff == ST_IDLE) ? cmp_addr : seq_addr_ff;

    kls_param_mem #(.DW(16)) u_mem
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(par_wr),
        .wr_addr(par_addr),
        .wr_data(par_wdata),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data_ff(rd_data)
    );

    // working copies of slots 0-4 follow every write the same cycle it reaches the store
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            lim_ff <= `KLS_RST_RETARD_LIM;
            shut_ff <= `KLS_RST_SHUTDOWN;
            decay_ff <= `KLS_RST_DECAY_STEP;
            hold_ms_ff <= `KLS_RST_HOLD_MS;
            rise_ff <= `KLS_RST_RISE_STEP;
        end
        else if (par_wr)
        begin
            case (par_addr)
                `KLS_PAR_RETARD_LIM: lim_ff <= par_wdata;
                `KLS_PAR_SHUTDOWN: shut_ff <= par_wdata;
                `KLS_PAR_DECAY_STEP: decay_ff <= par_wdata;
                `KLS_PAR_HOLD_MS: hold_ms_ff <= par_wdata;
                `KLS_PAR_RISE_STEP: rise_ff <= par_wdata;
                default: lim_ff <= lim_ff;
            endcase
        end
    end

    // gate pin synchroniser and 1 ms ramp tick
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            gate_s1_ff <= 1'b0;
            gate_s2_ff <= 1'b0;
            gate_d_ff <= 1'b0;
            tick_cnt_ff <= 17'h00000;
            tick_ff <= 1'b0;
        end
        else
        begin
            gate_s1_ff <= cycle_gate;
            gate_s2_ff <= gate_s1_ff;
            gate_d_ff <= gate_s2_ff;
            tick_ff <= (tick_cnt_ff == TICK_CYCLES - 1);
            if (tick_cnt_ff == TICK_CYCLES - 1)
                tick_cnt_ff <= 17'h00000;
            else
                tick_cnt_ff <= tick_cnt_ff + 17'h00001;
        end
    end

    // energy outside the window is noise; summing saturates, never wraps
    always @(posedge mclk)
    begin
        if (!rst_n)
            energy_ff <= 32'h00000000;
        else if (cycle_end)
            energy_ff <= 32'h00000000;
        else if (gate_s2_ff && sample_valid)
            energy_ff <= sum[32] ? 32'hFFFFFFFF : sum[31:0];
    end

    // per-cycle verdict and the retard ramp
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            knocking_ff <= 1'b0;
            trip_ff <= 1'b0;
            power_cut_request_ff <= 1'b0;
            level_ff <= 12'h000;
            hold_ff <= 16'h0000;
        end
        else if (cycle_end)
        begin
            knocking_ff <= knock_now;
            trip_ff <= energy_ff > {16'h0000, shut_ff};
            if (knock_now)
            begin
                level_ff <= level_up[12] ? `KLS_LVL_FULL : level_up[11:0];
                if (level_ff == `KLS_LVL_FULL)
                    power_cut_request_ff <= 1'b1;
                hold_ff <= 16'h0000;
            end
            else if (power_cut_request_ff)
            begin
                power_cut_request_ff <= 1'b0;
                hold_ff <= hold_ms_ff;
            end
        end
        else if (tick_ff && !knocking_ff && !power_cut_request_ff)
        begin
            if (hold_ff != 16'h0000)
                hold_ff <= hold_ff - 16'h0001;
            else if ({4'h0, level_ff} > decay_ff)
                level_ff <= level_ff - decay_ff[11:0];
            else
                level_ff <= 12'h000;
        end
    end

    // one level, two ranges: 0-5 V full span, 4-20 mA as offset plus 80 %
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            volt_code_ff <= 12'h000;
            cur_code_ff <= `KLS_CUR_OFFSET;
        end
        else
        begin
            volt_code_ff <= level_ff;
            cur_code_ff <= `KLS_CUR_OFFSET
                + cur_prod[`KLS_CUR_SHIFT+11:`KLS_CUR_SHIFT];
        end
    end

    // host sequencer; requests arriving while busy are dropped
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_ff <= ST_IDLE;
            seq_addr_ff <= 3'h0;
            rd_pend_ff <= 1'b0;
            cmp_data_ff <= 16'h0000;
            host_busy_ff <= 1'b0;
            rep_valid_ff <= 1'b0;
            rep_addr_ff <= 3'h0;
            rep_data_ff <= 16'h0000;
            cmp_done_ff <= 1'b0;
            cmp_match_ff <= 1'b0;
        end
        else
        begin
            rep_valid_ff <= 1'b0;
            cmp_done_ff <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    if (connect_req)
                    begin
                        state_ff <= ST_VERSION;
                        host_busy_ff <= 1'b1;
                    end
                    else if (compare_settings_cmd)
                    begin
                        cmp_data_ff <= cmp_data;
                        state_ff <= ST_VERIFY;
                        host_busy_ff <= 1'b1;
                    end
                end
                ST_VERSION:
                begin
                    rep_valid_ff <= 1'b1;
                    rep_addr_ff <= `KLS_REP_VERSION;
                    rep_data_ff <= FW_VERSION;
                    seq_addr_ff <= 3'h0;
                    rd_pend_ff <= 1'b0;
                    state_ff <= ST_REPORT;
                end
                ST_REPORT:
                begin
                    rd_pend_ff <= !rd_pend_ff;
                    if (rd_pend_ff)
                    begin
                        rep_valid_ff <= 1'b1;
                        rep_addr_ff <= seq_addr_ff;
                        rep_data_ff <= rd_data;
                        seq_addr_ff <= seq_addr_ff + 3'h1;
                        if (seq_addr_ff == `KLS_PAR_LAST)
                        begin
                            state_ff <= ST_IDLE;
                            host_busy_ff <= 1'b0;
                        end
                    end
                end
                ST_VERIFY:
                begin
                    cmp_done_ff <= 1'b1;
                    cmp_match_ff <= rd_data == cmp_data_ff;
                    state_ff <= ST_IDLE;
                    host_busy_ff <= 1'b0;
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                    host_busy_ff <= 1'b0;
                end
            endcase
        end
    end
endmodule // kls_supervisor

// ==== src/kls_regs.vh ====
// constants of the knock level supervisor: parameter slots, reset values,
// report codes, output scaling and timing.
// assumes a 100 MHz mclk and 16-bit parameter words.
`ifndef KLS_REGS_VH
`define KLS_REGS_VH

// parameter slots in the non-volatile store
`define KLS_PAR_RETARD_LIM 3'h0
`define KLS_PAR_SHUTDOWN 3'h1
`define KLS_PAR_DECAY_STEP 3'h2
`define KLS_PAR_HOLD_MS 3'h3
`define KLS_PAR_RISE_STEP 3'h4
`define KLS_PAR_LAST 3'h4
`define KLS_PAR_COUNT 8

// power-up contents of the store
`define KLS_RST_RETARD_LIM 16'h4000
`define KLS_RST_SHUTDOWN 16'hC000
`define KLS_RST_DECAY_STEP 16'h0004
`define KLS_RST_HOLD_MS 16'h03E8
`define KLS_RST_RISE_STEP 16'h0100

// report address that carries the firmware version word
`define KLS_REP_VERSION 3'h7

// retard level and analog scaling (12-bit converters)
`define KLS_LVL_FULL 12'hFFF
`define KLS_CUR_OFFSET 12'h333
`define KLS_CUR_MULT 14'h3333
`define KLS_CUR_SHIFT 14

// energy fields: product of the band sample squared, scaled down
`define KLS_ENERGY_SHIFT 8

// ramp tick: 1 ms
`define KLS_TICK_NS 1000000
`define KLS_CLK_NS 10
`define KLS_TICK_CYCLES (`KLS_TICK_NS / `KLS_CLK_NS)

`endif

// ==== src/kls_param_mem.v ====
// parameter store of the knock level supervisor: one write port, one read
// port with registered read data.
// assumes rst_n models power-up; afterwards contents change only by writes.
`timescale 1ns/1ns
`include "kls_regs.vh"

module kls_param_mem
(
    mclk,
    rst_n,
    wr_en,
    wr_addr,
    wr_data,
    rd_en,
    rd_addr,
    rd_data_ff
);
    parameter DW = 16;
    input wire mclk;
    input wire rst_n;
    input wire wr_en;
    input wire [2:0] wr_addr;
    input wire [DW-1:0] wr_data;
    input wire rd_en;
    input wire [2:0] rd_addr;
    output reg [DW-1:0] rd_data_ff;

    reg [DW-1:0] mem_ff [0:`KLS_PAR_COUNT-1];

    function [DW-1:0] power_up_value;
        input integer a;
        begin
            case (a)
                `KLS_PAR_RETARD_LIM: power_up_value = `KLS_RST_RETARD_LIM;
                `KLS_PAR_SHUTDOWN: power_up_value = `KLS_RST_SHUTDOWN;
                `KLS_PAR_DECAY_STEP: power_up_value = `KLS_RST_DECAY_STEP;
                `KLS_PAR_HOLD_MS: power_up_value = `KLS_RST_HOLD_MS;
                `KLS_PAR_RISE_STEP: power_up_value = `KLS_RST_RISE_STEP;
                default: power_up_value = {DW{1'b0}};
            endcase
        end
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < `KLS_PAR_COUNT; gi = gi + 1)
        begin : g_word
            always @(posedge mclk)
            begin
                if (!rst_n)
                    mem_ff[gi] <= power_up_value(gi);
                else if (wr_en && wr_addr == gi)
                    mem_ff[gi] <= wr_data;
            end
        end
    endgenerate

    always @(posedge mclk)
    begin
        if (!rst_n)
            rd_data_ff <= {DW{1'b0}};
        else if (rd_en)
            rd_data_ff <= mem_ff[rd_addr];
    end
endmodule // kls_param_mem

// ==== sim/kls_knock_src.sv ====
// sensor-side model: ignition window and band-pass samples per cycle.
// assumes one start pulse per working cycle, only while busy is low.
`timescale 1ns/1ns

module kls_knock_src (
    input logic mclk,
    input logic start,
    input logic [11:0] amp,
    output logic cycle_gate,
    output logic signed [11:0] band_sample,
    output logic sample_valid,
    output logic busy
);
    logic [5:0] cnt_ff = 6'h0;
    logic [11:0] amp_ff = 12'h0;
    logic gate_ff = 1'b0;
    logic [11:0] smp_ff = 12'h7FF;

    assign busy = cnt_ff != 6'h0;
    // half the window samples are valid; outside the window the noise is
    // marked valid, so only the gate can keep it out of the energy
    assign sample_valid = !busy || cnt_ff[1];
    assign cycle_gate = gate_ff;
    assign band_sample = smp_ff;

    always @(posedge mclk)
    begin
        if (start)
        begin
            cnt_ff <= 6'h24;
            amp_ff <= amp;
        end
        else if (busy)
            cnt_ff <= cnt_ff - 6'h1;
        gate_ff <= cnt_ff > 6'h4;
        // vibration outlasts the window so the late-synced gate sees no noise
        if (busy)
            smp_ff <= cnt_ff[0] ? amp_ff : -amp_ff;
        else
            smp_ff <= smp_ff[0] ? 12'h800 : 12'h7FF;
    end
endmodule // kls_knock_src

// ==== sim/kls_supervisor_chk.sv ====
// port checker for the knock level supervisor.
// assumes it is bound into kls_supervisor; one clock, sync reset.
`timescale 1ns/1ns

module kls_supervisor_chk #(parameter FW_VERSION = 16'h0102) (
    input logic mclk,
    input logic rst_n,
    input logic connect_req,
    input logic compare_settings_cmd,
    input logic host_busy_ff,
    input logic rep_valid_ff,
    input logic [2:0] rep_addr_ff,
    input logic [15:0] rep_data_ff,
    input logic cmp_done_ff,
    input logic knocking_ff,
    input logic power_cut_request_ff,
    input logic [11:0] volt_code_ff,
    input logic [11:0] cur_code_ff
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    report_start_a: assert property (
        connect_req && !host_busy_ff |=> host_busy_ff ##1 (rep_valid_ff &&
        rep_addr_ff == 3'h7 && rep_data_ff == FW_VERSION) ##2
        (rep_valid_ff && rep_addr_ff == 3'h0)) else $error("bad report");
    cmp_timing_a: assert property (
        compare_settings_cmd && !connect_req && !host_busy_ff |=>
        host_busy_ff ##1 (cmp_done_ff && !host_busy_ff))
        else $error("bad compare timing");
    cur_scale_a: assert property (
        cur_code_ff == 12'(32'h333 + ((32'(volt_code_ff) * 32'h3333) >> 14)))
        else $error("current code off scale");
    knock_rise_a: assert property (
        $rose(knocking_ff) |=> volt_code_ff > $past(volt_code_ff) ||
        volt_code_ff == 12'hFFF) else $error("level did not rise");
    pcut_set_a: assert property (
        $rose(power_cut_request_ff) |-> knocking_ff &&
        volt_code_ff == 12'hFFF) else $error("early power cut");
    pcut_clear_a: assert property (
        $fell(power_cut_request_ff) |-> !knocking_ff)
        else $error("power cut dropped while knocking");
    hold_full_a: assert property (
        $fell(power_cut_request_ff) |-> (volt_code_ff == 12'hFFF) [*8])
        else $error("level left full scale during hold");
    level_rise_a: assert property (
        volt_code_ff > $past(volt_code_ff) |-> $past(knocking_ff))
        else $error("level rose without knocking");
endmodule // kls_supervisor_chk

bind kls_supervisor kls_supervisor_chk #(.FW_VERSION(FW_VERSION)) u_chk (
    .mclk(mclk),
    .rst_n(rst_n),
    .connect_req(connect_req),
    .compare_settings_cmd(compare_settings_cmd),
    .host_busy_ff(host_busy_ff),
    .rep_valid_ff(rep_valid_ff),
    .rep_addr_ff(rep_addr_ff),
    .rep_data_ff(rep_data_ff),
    .cmp_done_ff(cmp_done_ff),
    .knocking_ff(knocking_ff),
    .power_cut_request_ff(power_cut_request_ff),
    .volt_code_ff(volt_code_ff),
    .cur_code_ff(cur_code_ff));

// ==== sim/testbench.sv ====
// self-checking bench for the knock level supervisor.
// assumes the sensor model kls_knock_src and the bound checker.
`timescale 1ns/1ns
`include "kls_regs.vh"

module testbench;
    localparam FW = 16'h0102; // arbitrary value
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic par_wr = 1'b0, connect_req = 1'b0, compare_settings_cmd = 1'b0;
    logic [2:0] par_addr = 3'h0, cmp_addr = 3'h0;
    logic [15:0] par_wdata = 16'h0, cmp_data = 16'h0;
    logic src_start = 1'b0, src_busy, cycle_gate, sample_valid;
    logic [11:0] src_amp = 12'h0, volt_code_ff, cur_code_ff;
    logic signed [11:0] band_sample;
    logic host_busy_ff, rep_valid_ff, cmp_done_ff, cmp_match_ff, trip_ff;
    logic knocking_ff, power_cut_request_ff;
    logic [2:0] rep_addr_ff;
    logic [15:0] rep_data_ff;
    logic [15:0] exp_par [0:7];
    logic [31:0] expq [$];
    logic [31:0] rnd;
    int fails = 0;
    int tests_run = 0;

    always #5 mclk = ~mclk;

    kls_knock_src u_kls_knock_src (.mclk(mclk), .start(src_start),
        .amp(src_amp), .cycle_gate(cycle_gate), .band_sample(band_sample),
        .sample_valid(sample_valid), .busy(src_busy));
    kls_supervisor #(.TICK_CYCLES(10), .FW_VERSION(FW)) u_kls_supervisor (
        .mclk(mclk), .rst_n(rst_n), .cycle_gate(cycle_gate),
        .band_sample(band_sample), .sample_valid(sample_valid),
        .par_wr(par_wr), .par_addr(par_addr), .par_wdata(par_wdata),
        .connect_req(connect_req),
        .compare_settings_cmd(compare_settings_cmd),
        .cmp_addr(cmp_addr), .cmp_data(cmp_data),
        .host_busy_ff(host_busy_ff), .rep_valid_ff(rep_valid_ff),
        .rep_addr_ff(rep_addr_ff), .rep_data_ff(rep_data_ff),
        .cmp_done_ff(cmp_done_ff), .cmp_match_ff(cmp_match_ff),
        .knocking_ff(knocking_ff),
        .power_cut_request_ff(power_cut_request_ff), .trip_ff(trip_ff),
        .volt_code_ff(volt_code_ff), .cur_code_ff(cur_code_ff));

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            fails++;
            $display("wrong value at %0t: %h expected %h", $time, seen, want);
        end
    endtask

    task automatic conclude;
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // samples 1 ns past the edge so the design's updates have landed
    task automatic wait_idle;
        int i;
        for (i = 0; i < 300; i++)
        begin
            @(posedge mclk);
            #1;
            if (!host_busy_ff && !src_busy)
                break;
        end
        if (i == 300)
        begin
            fails++;
            conclude();
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        exp_par[a] = d;
        @(posedge mclk);
        par_wr <= 1'b1;
        par_addr <= a;
        par_wdata <= d;
        @(posedge mclk);
        par_wr <= 1'b0;
    endtask

    task automatic report;
        expq.push_back({13'h0, `KLS_REP_VERSION, FW});
        for (int k = 0; k <= 4; k++)
            expq.push_back({13'h0, k[2:0], exp_par[k]});
        @(posedge mclk);
        connect_req <= 1'b1;
        @(posedge mclk);
        connect_req <= 1'b0;
        wait_idle();
    endtask

    task automatic cmpr(input logic [2:0] a, input logic [15:0] d);
        expq.push_back({31'h0, exp_par[a] == d});
        @(posedge mclk);
        compare_settings_cmd <= 1'b1;
        cmp_addr <= a;
        cmp_data <= d;
        @(posedge mclk);
        compare_settings_cmd <= 1'b0;
        wait_idle();
    endtask

    task automatic burn(input logic [11:0] amp);
        @(posedge mclk);
        src_start <= 1'b1;
        src_amp <= amp;
        @(posedge mclk);
        src_start <= 1'b0;
        wait_idle();
        repeat (8) @(posedge mclk);
        #1;
    endtask

    function automatic logic [31:0] take;
        return expq.size() ? expq.pop_front() : 32'hFFFFFFFF;
    endfunction

    always @(negedge mclk)
    begin
        if (rep_valid_ff)
            check({13'h0, rep_addr_ff, rep_data_ff}, take());
        if (cmp_done_ff)
            check({31'h0, cmp_match_ff}, take());
    end

    initial
    begin
        exp_par = '{`KLS_RST_RETARD_LIM, `KLS_RST_SHUTDOWN, `KLS_RST_DECAY_STEP,
            `KLS_RST_HOLD_MS, `KLS_RST_RISE_STEP, 16'h0, 16'h0, 16'h0};
        void'($urandom(32'h5F68AD8D));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        check({volt_code_ff, cur_code_ff}, {12'h0, 12'h333});
        check({knocking_ff, power_cut_request_ff, trip_ff}, 3'h0);
        report();
        rnd = $urandom;
        wr(3'h5, rnd[15:0]);
        // new limits sit so that later cycles land between old and new
        wr(`KLS_PAR_RETARD_LIM, 16'h2000);
        wr(`KLS_PAR_SHUTDOWN, 16'h8000);
        wr(`KLS_PAR_HOLD_MS, 16'h0002);
        wr(`KLS_PAR_DECAY_STEP, 16'h0100);
        wr(`KLS_PAR_RISE_STEP, 16'h0800);
        cmpr(3'h5, rnd[15:0] ^ 16'h0001);
        cmpr(`KLS_PAR_DECAY_STEP, 16'h0100);
        report();
        burn(12'h064);
        check(knocking_ff, 1'b0);
        burn(12'h190);
        check({knocking_ff, volt_code_ff}, {1'b1, 12'h800});
        check(cur_code_ff, 12'h999);
        burn(12'h258);
        check({volt_code_ff, power_cut_request_ff, trip_ff}, 14'h3FFC);
        burn(12'h320);
        check({power_cut_request_ff, trip_ff}, 2'b11);
        burn(12'h064);
        check({knocking_ff, power_cut_request_ff, trip_ff}, 3'h0);
        check(volt_code_ff, 12'hFFF);
        repeat (40) @(posedge mclk);
        #1;
        check(volt_code_ff <= 12'hDFF && volt_code_ff >= 12'hBFF, 1'b1);
        check(expq.size(), 0);
        conclude();
    end
endmodule // testbench
